// *** src/mpr_port.sv ***
// Network port pin logic: receive, nibble and serial transmit, management and address detection
// Notes on behaviour
// RULE1 - PHY supplies receive clock at a quarter of the line bit rate.
// RULE2 - PHY keeps its clocks glitch free when switching speed or source.
// RULE3 - Receive nibbles captured on rising receive clock only while data valid.
// RULE4 - PHY holds data valid from delimiter nibble through last CRC nibble.
// RULE5 - Receive error during data valid flags CRC error; ignored otherwise.
// RULE6 - Collision and carrier sense inputs reported as medium state.
// RULE7 - Management clock runs 2.5 MHz only during operations, else low.
// RULE8 - Management pin driven for header and write data, released otherwise.
// RULE9 - Management pin changes only on management clock falling edges.
// RULE10 - Serial data sampled on serial receive clock rise while valid high.
// RULE11 - Serial mode times transmit and receive activity from transmit clock.
// RULE12 - Serial transmit data sent bit by bit, valid only with enable.
// RULE13 - Frame rejected when internal filter or external reject input rejects.
// RULE14 - Serial strobe rises after second one of delimiter, toggles every 4 bits.
// RULE15 - Nibble strobe rises one receive clock after delimiter found.
// RULE16 - Nibble strobe toggles every nibble, active only during reception.
// RULE17 - Serial monitor data and clock outputs stay quiet in nibble mode.
// RULE18 - Serial mode tagging takes tag inputs on data bit 0 and valid pins.
// RULE19 - Nibble mode tagging takes tag inputs on serial monitor pins.
// RULE20 - Transmit nibbles change on transmit clock rise, zero while disabled.
// RULE21 - Transmit enable spans the frame, falls at the edge after the last nibble.
// RULE22 - Transmit error output always low.
// RULE23 - Management frame: preamble, start, opcode, addresses, turnaround, 16 data.
// RULE24 - Strobe and monitor outputs only while external detection is enabled.
`timescale 1ns/1ns
module mpr_port (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               mii_select,
  input  wire logic               external_detect_select,
  input  wire logic               frame_tagging_enable,
  input  wire logic               rx_clk_pin,
  input  wire logic [3:0]         rxd_pin,
  input  wire logic               rx_dv_pin,
  input  wire logic               rx_er_pin,
  input  wire logic               crs_pin,
  input  wire logic               col_pin,
  input  wire logic               tx_clk_pin,
  output logic [3:0]              txd_pin,
  output logic                    tx_en_pin,
  output logic                    tx_er_pin,
  output logic                    mdc_pin,
  output logic                    mdio_out,
  output logic                    mdio_oe,
  input  wire logic               mdio_in,
  input  wire logic               external_reject_n,
  output logic                    frame_byte_delimiter_strobe,
  output logic                    frame_byte_delimiter_strobe_oe,
  output logic                    serial_rx_data_monitor,
  output logic                    serial_rx_data_monitor_oe,
  input  wire logic               nibble_port_frame_tag_data,
  output logic                    serial_rx_data_monitor_clock,
  output logic                    serial_rx_data_monitor_clock_oe,
  input  wire logic               nibble_port_frame_tag_enable,
  input  wire logic               tx_valid,
  input  wire logic [3:0]         tx_nibble,
  output logic                    tx_ready,
  output logic                    rx_valid,
  output logic [3:0]              rx_nibble,
  output logic                    rx_end,
  output mpr_pkg::mpr_rxst_s      rx_status,
  input  wire logic               internal_reject,
  output logic                    carrier_sense,
  output logic                    collision,
  output logic                    rx_tag_data,
  output logic                    rx_tag_enable,
  input  wire logic               mgmt_valid,
  input  wire mpr_pkg::mpr_mreq_s mgmt_req,
  output logic                    mgmt_ready,
  output logic [15:0]             mgmt_rd_data,
  output logic                    mgmt_done
);
  import mpr_pkg::*;

  // ==========================================================
  // Serial functions of the shared pins
  wire serial_receive_clock_in  = rx_clk_pin;
  wire serial_receive_data_in   = rx_er_pin;
  wire serial_receive_valid_in  = crs_pin;
  wire serial_collision_in      = col_pin;
  wire serial_transmit_clock_in = tx_clk_pin;
  wire serial_frame_tag_data    = rxd_pin[0];
  wire serial_frame_tag_enable  = rx_dv_pin;

  mpr_rx_e    st_q;
  mpr_rx_e    st_d;
  logic       rxc_q;
  logic       txc_q;
  logic       sbit_q;
  logic       shav_q;
  logic       prv_q;
  logic [1:0] bcnt_q;
  logic [3:0] nib_q;
  logic       dlm_q;
  logic       err_q;
  logic       rej_q;
  logic       cls_q;
  logic       mon_q;
  logic       mclk_q;
  logic [1:0] tbc_q;
  logic [2:0] tsh_q;

  // ==========================================================
  // Event decode
  // Inputs are synchronous to ref_clk, so edges come from one stored sample
  wire rx_rise = serial_receive_clock_in && !rxc_q;
  wire tx_rise = serial_transmit_clock_in && !txc_q;
  wire in_frm  = (st_q != R_IDLE);
  wire dv      = rx_dv_pin;
  wire mii_ev  = mii_select && rx_rise;
  // RULE10 sample while valid
  wire s_cap   = !mii_select && rx_rise && serial_receive_valid_in;
  // RULE11 serial work on transmit clock
  wire ser_ev  = !mii_select && tx_rise && shav_q;
  wire mii_end = mii_ev && !dv && in_frm;
  wire ser_end = !mii_select && !serial_receive_valid_in && !shav_q && in_frm;
  wire frm_end = mii_end || ser_end;
  wire mii_sfd = mii_ev && dv && !rx_er_pin && (st_q != R_DATA) && (rxd_pin == NIB_SFD);
  // RULE14 second one of delimiter
  wire ser_sfd = ser_ev && (st_q == R_PRE) && prv_q && sbit_q;
  // RULE3 capture only with valid
  wire mii_dat = mii_ev && dv && (st_q == R_DATA);
  wire ser_dat = ser_ev && (st_q == R_DATA);
  wire nib_done = mii_dat || (ser_dat && bcnt_q == BIT_LAST);
  wire [3:0] nib_in = mii_select ? rxd_pin : {sbit_q, nib_q[3:1]};
  // RULE16 toggle every nibble
  wire tog = mii_dat || (ser_dat && bcnt_q == BIT_FIRST);
  wire enter = (st_d == R_DATA) && (st_q != R_DATA);
  // RULE13 reject by OR
  wire rej_now = rej_q || !external_reject_n || internal_reject;
  wire tag_on = external_detect_select && frame_tagging_enable;
  // RULE18 serial tag pins
  // RULE19 nibble mode tag pins
  wire tag_d = mii_select ? nibble_port_frame_tag_data : serial_frame_tag_data;
  wire tag_e = mii_select ? nibble_port_frame_tag_enable : serial_frame_tag_enable;

  // ==========================================================
  // Receive state
  always_comb begin
    st_d = st_q;
    case (st_q)
      R_IDLE: begin
        if (mii_sfd) st_d = R_DATA;
        else if ((mii_ev && dv) || ser_ev) st_d = R_PRE;
      end
      R_PRE: begin
        if (frm_end) st_d = R_IDLE;
        else if (mii_sfd || ser_sfd) st_d = R_DATA;
      end
      R_DATA: if (frm_end) st_d = R_IDLE;
      default: st_d = R_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q   <= R_IDLE;
      rxc_q  <= 1'b0;
      txc_q  <= 1'b0;
      sbit_q <= 1'b0;
      shav_q <= 1'b0;
      prv_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      rxc_q  <= serial_receive_clock_in;
      txc_q  <= serial_transmit_clock_in;
      if (s_cap) sbit_q <= serial_receive_data_in;
      // A new bit wins over the hand-off of the old one
      shav_q <= s_cap || (shav_q && !ser_ev && !mii_select);
      if (ser_ev) prv_q <= sbit_q;
    end
  end

  // ==========================================================
  // Receive data, strobe and status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bcnt_q    <= BIT_FIRST;
      nib_q     <= '0;
      dlm_q     <= 1'b0;
      rx_valid  <= 1'b0;
      rx_nibble <= '0;
      rx_end    <= 1'b0;
      rx_status <= '0;
    end else begin
      if (enter) bcnt_q <= BIT_FIRST;
      else if (ser_dat) bcnt_q <= bcnt_q + BIT_STEP;
      if (ser_dat) nib_q <= nib_in;
      // RULE15 rises on first address nibble
      // RULE24 gated by detection enable
      dlm_q <= (st_d == R_DATA) && external_detect_select && (tog ? !dlm_q : dlm_q);
      rx_valid <= nib_done;
      if (nib_done) rx_nibble <= nib_in;
      rx_end <= frm_end;
      if (frm_end) rx_status <= {err_q, rej_now, cls_q || col_pin};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !in_frm) begin
      err_q <= 1'b0;
      rej_q <= 1'b0;
      cls_q <= 1'b0;
    end else begin
      // RULE5 error only with valid
      err_q <= err_q || (mii_ev && dv && rx_er_pin);
      rej_q <= rej_now;
      cls_q <= cls_q || col_pin;
    end
  end

  // ==========================================================
  // Monitor outputs, tags, medium state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mon_q         <= 1'b0;
      mclk_q        <= 1'b0;
      rx_tag_data   <= 1'b0;
      rx_tag_enable <= 1'b0;
      carrier_sense <= 1'b0;
      collision     <= 1'b0;
    end else begin
      // RULE17 quiet in nibble mode
      mon_q         <= !mii_select && serial_receive_data_in;
      mclk_q        <= !mii_select && serial_receive_clock_in;
      rx_tag_data   <= tag_on && tag_d;
      rx_tag_enable <= tag_on && tag_e;
      // RULE6 medium state
      carrier_sense <= crs_pin;
      collision     <= serial_collision_in;
    end
  end

  assign frame_byte_delimiter_strobe     = dlm_q;
  assign frame_byte_delimiter_strobe_oe  = external_detect_select;
  assign serial_rx_data_monitor          = mon_q;
  assign serial_rx_data_monitor_clock    = mclk_q;
  // Pins turn to tag inputs in nibble mode with tagging on
  assign serial_rx_data_monitor_oe       = external_detect_select && !(mii_select && tag_on);
  assign serial_rx_data_monitor_clock_oe = external_detect_select && !(mii_select && tag_on);

  // ==========================================================
  // Transmit
  assign tx_ready = tx_rise && tx_valid && (mii_select || tbc_q == BIT_FIRST);
  // RULE22 error held low
  assign tx_er_pin = 1'b0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txd_pin   <= '0;
      tx_en_pin <= 1'b0;
      tbc_q     <= BIT_FIRST;
      tsh_q     <= '0;
    end else if (tx_rise) begin
      if (mii_select) begin
        // RULE20 zero while disabled
        // RULE21 enable follows the stream
        tx_en_pin <= tx_valid;
        txd_pin   <= tx_valid ? tx_nibble : 4'h0;
        tbc_q     <= BIT_FIRST;
      end else if (tbc_q == BIT_FIRST) begin
        // RULE12 serial bits, lsb first
        tx_en_pin <= tx_valid;
        txd_pin   <= {3'h0, tx_valid && tx_nibble[0]};
        tsh_q     <= tx_nibble[3:1];
        if (tx_valid) tbc_q <= BIT_STEP;
      end else begin
        txd_pin <= {3'h0, tsh_q[0]};
        tsh_q   <= {1'b0, tsh_q[2:1]};
        tbc_q   <= tbc_q + BIT_STEP;
      end
    end
  end

  // ==========================================================
  // Management
  mpr_mgmt u_mgmt (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .req_valid (mgmt_valid),
    .req_ready (mgmt_ready),
    .req       (mgmt_req),
    .rd_data   (mgmt_rd_data),
    .done      (mgmt_done),
    .mdc       (mdc_pin),
    .mdio_out  (mdio_out),
    .mdio_oe   (mdio_oe),
    .mdio_in   (mdio_in)
  );

  // ==========================================================
  // Checks
  sequence s_mii_sfd;
    mii_ev && dv && !rx_er_pin && st_q == R_PRE && rxd_pin == NIB_SFD;
  endsequence

  property p_strobe_after_sfd;
    @(posedge ref_clk) disable iff (rst) s_mii_sfd |=> (st_q == R_DATA && !dlm_q);
  endproperty
  a_strobe_after_sfd: assert property (p_strobe_after_sfd) else $error("strobe early"); // RULE15

  property p_strobe_on_edge;
    @(posedge ref_clk) disable iff (rst)
      (mii_select && $past(mii_select) && $changed(dlm_q)) |-> $past(rx_rise);
  endproperty
  a_strobe_on_edge: assert property (p_strobe_on_edge) else $error("strobe off clock"); // RULE16

  property p_capture;
    @(posedge ref_clk) disable iff (rst)
      (rx_valid && $past(mii_select)) |-> ($past(dv) && rx_nibble == $past(rxd_pin));
  endproperty
  a_capture: assert property (p_capture) else $error("nibble capture wrong"); // RULE3

  property p_reject;
    @(posedge ref_clk) disable iff (rst) (rx_end && $past(!external_reject_n)) |-> rx_status.reject;
  endproperty
  a_reject: assert property (p_reject) else $error("reject lost"); // RULE13

  property p_txd_idle;
    @(posedge ref_clk) disable iff (rst) !tx_en_pin |-> (txd_pin == 4'h0 && !tx_er_pin);
  endproperty
  a_txd_idle: assert property (p_txd_idle) else $error("transmit pins not idle"); // RULE20

  property p_serial_transmit_valid_out_edge;
    @(posedge ref_clk) disable iff (rst) $changed(tx_en_pin) |-> $past(tx_rise);
  endproperty
  a_serial_transmit_valid_out_edge: assert property (p_serial_transmit_valid_out_edge) else $error("enable off clock"); // RULE21

  property p_quiet_monitor;
    @(posedge ref_clk) disable iff (rst)
      (mii_select && $past(mii_select) && $past(mii_select, 2))
        |-> ($stable(serial_rx_data_monitor) && $stable(serial_rx_data_monitor_clock));
  endproperty
  a_quiet_monitor: assert property (p_quiet_monitor) else $error("monitor moved"); // RULE17

  property p_detect_off;
    @(posedge ref_clk) disable iff (rst)
      !external_detect_select |-> (!frame_byte_delimiter_strobe_oe && !serial_rx_data_monitor_oe);
  endproperty
  a_detect_off: assert property (p_detect_off) else $error("detect pins driven"); // RULE24

endmodule // mpr_port

// *** src/mpr_pkg.sv ***
// Shared constants and types for the network port receive and address detect block
package mpr_pkg;

  // ==========================================================
  // Clock rates and management clock timing
  localparam int CLK_KHZ = 250000;
  localparam int MDC_KHZ = 2500;
  localparam int MDC_HALF = CLK_KHZ / (2 * MDC_KHZ);
  localparam logic [6:0] MDC_HALF_LAST = 7'(MDC_HALF - 1);
  localparam logic [6:0] PH_STEP = 7'h1;

  // ==========================================================
  // Management frame layout, msb sent first
  localparam logic [5:0] MFR_LAST = 6'h3f;
  localparam logic [5:0] MFR_TA = 6'h2e;
  localparam logic [5:0] MFR_DATA = 6'h30;
  localparam logic [5:0] MFR_STEP = 6'h1;
  localparam logic [31:0] MFR_PRE = 32'hffffffff;
  localparam logic [1:0] MFR_ST = 2'h1;
  localparam logic [1:0] MFR_OP_WR = 2'h1;
  localparam logic [1:0] MFR_OP_RD = 2'h2;
  localparam logic [1:0] MFR_TA_WR = 2'h2;
  localparam logic [1:0] MFR_TA_RD = 2'h0;

  // ==========================================================
  // Receive stream constants
  localparam logic [3:0] NIB_SFD = 4'hd;
  localparam logic [1:0] BIT_FIRST = 2'h0;
  localparam logic [1:0] BIT_STEP = 2'h1;
  localparam logic [1:0] BIT_LAST = 2'h3;

  // ==========================================================
  // Types
  typedef struct packed {
    logic        write;
    logic [4:0]  phy;
    logic [4:0]  regad;
    logic [15:0] wdata;
  } mpr_mreq_s;

  typedef struct packed {
    logic crc_err;
    logic reject;
    logic collision;
  } mpr_rxst_s;

  typedef enum logic [2:0] {
    R_IDLE = 3'h1,
    R_PRE  = 3'h2,
    R_DATA = 3'h4
  } mpr_rx_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'h1,
    M_RUN  = 2'h2
  } mpr_mg_e;

endpackage

// *** src/mpr_mgmt.sv ***
// Management clock and data pin engine
`timescale 1ns/1ns
module mpr_mgmt (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire mpr_pkg::mpr_mreq_s req,
  output logic [15:0]            rd_data,
  output logic                   done,
  output logic                   mdc,
  output logic                   mdio_out,
  output logic                   mdio_oe,
  input  wire logic              mdio_in
);
  import mpr_pkg::*;

  mpr_mg_e     st_q;
  logic [6:0]  ph_q;
  logic        hi_q;
  logic [5:0]  bit_q;
  logic [63:0] sh_q;
  logic        wr_q;
  logic [15:0] rd_q;
  logic        done_q;

  // ==========================================================
  // Decode
  wire        run    = (st_q == M_RUN);
  wire        ph_end = (ph_q == MDC_HALF_LAST);
  wire        fall   = run && hi_q && ph_end;
  wire        rise   = run && !hi_q && ph_end;
  wire        start  = !run && req_valid;
  wire [1:0]  op     = req.write ? MFR_OP_WR : MFR_OP_RD;
  wire [1:0]  ta     = req.write ? MFR_TA_WR : MFR_TA_RD;
  wire [15:0] wd     = req.write ? req.wdata : 16'h0;
  // RULE23 frame layout
  wire [63:0] frame0 = {MFR_PRE, MFR_ST, op, req.phy, req.regad, ta, wd};

  // ==========================================================
  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q   <= M_IDLE;
      ph_q   <= '0;
      hi_q   <= 1'b0;
      bit_q  <= '0;
      sh_q   <= '0;
      wr_q   <= 1'b0;
      rd_q   <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        M_IDLE: if (req_valid) begin
          st_q  <= M_RUN;
          sh_q  <= frame0;
          wr_q  <= req.write;
          bit_q <= '0;
          ph_q  <= '0;
          hi_q  <= 1'b0;
        end
        M_RUN: begin
          // RULE7 clock from time base
          ph_q <= ph_end ? '0 : ph_q + PH_STEP;
          if (ph_end) hi_q <= !hi_q;
          // Read bits are taken at the rising edge, one period after the PHY model launched them on the previous rise
          if (rise && !wr_q && bit_q >= MFR_DATA) rd_q <= {rd_q[14:0], mdio_in};
          // RULE9 shift on falling edge
          if (fall) begin
            sh_q  <= {sh_q[62:0], 1'b0};
            bit_q <= bit_q + MFR_STEP;
            if (bit_q == MFR_LAST) begin
              st_q   <= M_IDLE;
              done_q <= 1'b1;
            end
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  assign req_ready = !run;
  assign rd_data   = rd_q;
  assign done      = done_q;
  assign mdc       = hi_q;
  assign mdio_out  = sh_q[63];
  // RULE8 release for read data
  assign mdio_oe   = run && (wr_q || bit_q < MFR_TA);

  // ==========================================================
  // Checks
  property p_mdc_idle_low;
    @(posedge ref_clk) disable iff (rst) !run |-> !mdc;
  endproperty
  a_mdc_idle_low: assert property (p_mdc_idle_low) else $error("mdc not low when idle"); // RULE7

  property p_mdc_high_time;
    @(posedge ref_clk) disable iff (rst) $rose(mdc) |-> ##49 mdc ##1 !mdc;
  endproperty
  a_mdc_high_time: assert property (p_mdc_high_time) else $error("mdc high time wrong"); // RULE7

  property p_mdio_on_fall;
    @(posedge ref_clk) disable iff (rst)
      (run && $past(run) && $changed(mdio_out)) |-> ($past(hi_q) && !hi_q);
  endproperty
  a_mdio_on_fall: assert property (p_mdio_on_fall) else $error("mdio moved off falling edge"); // RULE9

  property p_read_release;
    @(posedge ref_clk) disable iff (rst) (run && !wr_q && bit_q >= MFR_TA) |-> !mdio_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("mdio driven during read"); // RULE8

  property p_start_preamble;
    @(posedge ref_clk) disable iff (rst) start |=> (mdio_oe && mdio_out && !mdc);
  endproperty
  a_start_preamble: assert property (p_start_preamble) else $error("frame not opened by preamble"); // RULE23

endmodule // mpr_mgmt

// *** testbench/mpr_phy_model.sv ***
// Behavioural PHY: nibble receive clock, receive frames, management slave
`timescale 1ns/1ns
module mpr_phy_model (
  input  wire logic ref_clk,
  output logic      clk_pin,
  output logic [3:0] rxd,
  output logic      rx_dv,
  output logic      rx_er,
  input  wire logic mdc,
  input  wire logic mdio_wire,
  input  wire logic mdio_oe,
  output logic      mdio_phy
);
  int          ph = 0;
  int          seed = 32758;
  int          nrise = 0;
  int          idle = 0;
  bit          busy = 0;
  logic        mdc_q = 1'b0;
  logic [63:0] frame_q = 64'h0;
  logic [15:0] rd_val = 16'h0;
  // ==========================================================
  // Clock and idle line noise
  initial begin
    clk_pin = 1'b0;
    rxd = 4'h0;
    rx_dv = 1'b0;
    rx_er = 1'b0;
    mdio_phy = 1'b1;
  end
  // clean nibble clock, ten reference cycles a period
  always @(posedge ref_clk) begin
    ph <= (ph == 9) ? 0 : ph + 1;
    clk_pin <= (ph >= 4);
    // Idle lines carry junk so an ignored input cannot pass by luck
    if (!busy) begin
      rxd <= 4'($random(seed));
      rx_er <= 1'($random(seed));
    end
  end
  // valid spans first queued nibble (preamble) to last nibble, data moves while clock low
  task automatic send(input logic [4:0] q[$]);
    busy = 1;
    foreach (q[i]) begin
      @(posedge ref_clk);
      while (ph != 1) @(posedge ref_clk);
      rx_dv <= 1'b1;
      {rx_er, rxd} <= q[i];
    end
    @(posedge ref_clk);
    while (ph != 1) @(posedge ref_clk);
    rx_dv <= 1'b0;
    busy = 0;
  endtask
  // capture the frame, drive turnaround zero and read data
  always @(posedge ref_clk) begin
    mdc_q <= mdc;
    idle <= mdc ? 0 : idle + 1;
    if (idle > 200)
      nrise <= 0;
    if (mdc && !mdc_q) begin
      frame_q <= {frame_q[62:0], mdio_wire};
      nrise <= nrise + 1;
    end
    if (mdc && !mdc_q && nrise >= 46 && nrise <= 62 && !mdio_oe)
      mdio_phy <= (nrise == 46) ? 1'b0 : rd_val[62-nrise];
    else if (nrise >= 63 || mdio_oe)
      mdio_phy <= 1'b1;
  end
endmodule // mpr_phy_model

// *** testbench/mpr_port_tb.sv ***
// Self-checking bench for the network port block
`timescale 1ns/1ns
module mpr_port_tb;
  import mpr_pkg::*;
  // ==========================================================
  // Signals
  logic ref_clk = 0, rst = 1, mii_select = 0, external_detect_select = 0;
  logic frame_tagging_enable = 0, crs_pin = 0, col_pin = 0, external_reject_n = 1;
  logic nibble_port_frame_tag_data = 0, nibble_port_frame_tag_enable = 0;
  logic tx_valid = 0, internal_reject = 0, mgmt_valid = 0;
  logic [3:0] tx_nibble = 0;
  mpr_mreq_s  mgmt_req = '0;
  logic rx_clk_pin, rx_dv_pin, rx_er_pin, mdio_phy;
  logic [3:0] rxd_pin, txd_pin, rx_nibble;
  logic tx_en_pin, tx_er_pin, mdc_pin, mdio_out, mdio_oe, tx_ready, rx_valid, rx_end;
  logic frame_byte_delimiter_strobe, frame_byte_delimiter_strobe_oe;
  logic serial_rx_data_monitor, serial_rx_data_monitor_oe;
  logic serial_rx_data_monitor_clock, serial_rx_data_monitor_clock_oe;
  logic carrier_sense, collision, rx_tag_data, rx_tag_enable, mgmt_ready, mgmt_done;
  logic [15:0] mgmt_rd_data;
  mpr_rxst_s  rx_status;
  // PHY model drives the management pin whenever the port does not
  wire mdio_in = mdio_oe ? mdio_out : mdio_phy;
  wire tx_clk_pin = rx_clk_pin;
  int err_total = 0, n_checks = 0, seed = 32758, nidx = 0, nend = 0;
  logic [3:0] exp_q[$];
  logic [2:0] st_exp = 0;
  logic rdy_q = 0;
  logic [1:0] crs_q = 0, mon_q = 0, tag_q = 0;
  logic [3:0] nib_q = 0;

  always #2 ref_clk = ~ref_clk;

  mpr_phy_model u_phy (.ref_clk, .clk_pin(rx_clk_pin), .rxd(rxd_pin), .rx_dv(rx_dv_pin),
    .rx_er(rx_er_pin), .mdc(mdc_pin), .mdio_wire(mdio_in), .mdio_oe, .mdio_phy);

  mpr_port u_dut (.ref_clk, .rst, .mii_select, .external_detect_select,
    .frame_tagging_enable, .rx_clk_pin, .rxd_pin, .rx_dv_pin, .rx_er_pin, .crs_pin,
    .col_pin, .tx_clk_pin, .txd_pin, .tx_en_pin, .tx_er_pin, .mdc_pin, .mdio_out,
    .mdio_oe, .mdio_in, .external_reject_n, .frame_byte_delimiter_strobe,
    .frame_byte_delimiter_strobe_oe, .serial_rx_data_monitor, .serial_rx_data_monitor_oe,
    .nibble_port_frame_tag_data, .serial_rx_data_monitor_clock,
    .serial_rx_data_monitor_clock_oe, .nibble_port_frame_tag_enable, .tx_valid,
    .tx_nibble, .tx_ready, .rx_valid, .rx_nibble, .rx_end, .rx_status, .internal_reject,
    .carrier_sense, .collision, .rx_tag_data, .rx_tag_enable, .mgmt_valid, .mgmt_req,
    .mgmt_ready, .mgmt_rd_data, .mgmt_done);
  // ==========================================================
  // Checking
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge ref_clk) if (!rst) begin
    if (rx_valid) begin
      check("rx_nibble", 64'(rx_nibble), 64'(exp_q.pop_front()));
      check("strobe", 64'(frame_byte_delimiter_strobe),
            64'(external_detect_select && nidx % 2 == 0));
      nidx++;
    end
    if (rx_end) begin
      check("rx_status", 64'(rx_status), 64'(st_exp));
      nend++;
    end
    check("medium", 64'({carrier_sense, collision}), 64'(crs_q));
    crs_q <= {crs_pin, col_pin};
    check("tag_pins", 64'({rx_tag_data, rx_tag_enable}), 64'(tag_q));
    tag_q <= !(external_detect_select && frame_tagging_enable) ? 2'h0 :
             mii_select ? {nibble_port_frame_tag_data, nibble_port_frame_tag_enable} :
             {rxd_pin[0], rx_dv_pin};
    check("strobe_oe", 64'(frame_byte_delimiter_strobe_oe), 64'(external_detect_select));
    check("tx_er", 64'(tx_er_pin), 64'h0);
    if (rdy_q)
      check("txd", 64'({tx_en_pin, txd_pin}),
            64'({1'b1, mii_select ? nib_q : {3'h0, nib_q[0]}}));
    rdy_q <= tx_ready;
    nib_q <= tx_nibble;
    check("monitor", 64'({serial_rx_data_monitor, serial_rx_data_monitor_clock}),
          64'(mon_q));
    mon_q <= mii_select ? 2'h0 : {rx_er_pin, rx_clk_pin};
    if (mgmt_ready)
      check("mdc_idle", 64'(mdc_pin), 64'h0);
  end
  // ==========================================================
  // Scenarios
  task automatic frame(input int f, input bit ser = 0);
    logic [4:0] q[$];
    logic [3:0] d;
    q = {5'h05, 5'h05, 5'h05, 5'h0d};
    // Serial preamble starts low so a stray bit before it cannot fake the closing ones
    if (ser) begin
      q = {5'h00};
      for (int i = 0; i < 8; i++)
        q.push_back({!i[0] || i == 7, 4'h0});
    end
    for (int i = 0; i < 4 + 2 * f; i++) begin
      d = 4'($random(seed));
      if (ser)
        for (int b = 0; b < 4; b++)
          q.push_back({d[b], 4'h0});
      else
        q.push_back({f == 1 && i == 2, d});
      exp_q.push_back(d);
    end
    // Reject table: none, internal, external, both; error and collision in between
    st_exp = {f == 1, f != 0, f == 2};
    nidx = 0;
    nend = 0;
    internal_reject <= f[0];
    external_reject_n <= !f[1];
    external_detect_select <= (f != 2);
    crs_pin <= 1'b1;
    col_pin <= (f == 2);
    u_phy.send(q);
    crs_pin <= 1'b0;
    col_pin <= 1'b0;
    repeat (20) @(posedge ref_clk);
    check("left", 64'(exp_q.size()), 64'h0);
    check("ends", 64'(nend), 64'h1);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    frame(0, 1);
    frame(3, 1);
    mii_select <= 1'b1;
    for (int f = 0; f < 4; f++)
      frame(f);
    for (int k = 0; k < 8; k++) begin
      frame_tagging_enable <= k[2];
      nibble_port_frame_tag_data <= k[0];
      nibble_port_frame_tag_enable <= k[1];
      repeat (3) @(posedge ref_clk);
      check("tag", 64'({rx_tag_data, rx_tag_enable}), 64'(k[2] ? {k[0], k[1]} : 2'h0));
    end
    for (int m = 0; m < 2; m++) begin
      mii_select <= m[0];
      tx_valid <= 1'b1;
      for (int k = 0; k < 12; k++) begin
        tx_nibble <= 4'($random(seed));
        @(posedge ref_clk);
        while (!tx_ready) @(posedge ref_clk);
      end
      tx_valid <= 1'b0;
      repeat (60) @(posedge ref_clk);
      check("tx_idle", 64'({tx_en_pin, txd_pin}), 64'h0);
    end
    for (int k = 0; k < 2; k++) begin
      u_phy.rd_val = 16'($random(seed));
      mgmt_req <= {1'(k == 0), 5'($random(seed)), 5'($random(seed)), 16'($random(seed))};
      mgmt_valid <= 1'b1;
      @(posedge ref_clk);
      mgmt_valid <= 1'b0;
      for (int w = 0; w < 7000 && mgmt_done !== 1'b1; w++)
        @(posedge ref_clk);
      // Long idle gap so the PHY model rearms its bit count
      repeat (250) @(posedge ref_clk);
      check("mgmt_frame", u_phy.frame_q, {MFR_PRE, MFR_ST, k ? MFR_OP_RD : MFR_OP_WR,
            mgmt_req.phy, mgmt_req.regad, MFR_TA_WR,
            k ? u_phy.rd_val : mgmt_req.wdata});
      if (k == 1)
        check("rd_data", 64'(mgmt_rd_data), 64'(u_phy.rd_val));
    end
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
endmodule // mpr_port_tb
